/* verilog/panel_power_sequencer.sv */
// embedded panel power sequencer with transcoder pll routing, axi4-lite slave
`timescale 1ns/1ps

module panel_power_sequencer
  import panel_seq_pkg::*;
#(
  parameter int TICK_CYCLES   = TIME_BASE_CYC,
  parameter int CYCLE_DELAY_T = CYCLE_TICKS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [19:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [19:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // display assets
  input  wire logic        pll_locked,
  input  wire logic        pipe_enabled,
  input  wire logic [3:0]  port_enabled,
  input  wire logic [1:0]  panel_transcoder,
  input  wire logic        reset_warning,
  // panel side
  output logic             panel_vdd,
  output logic             panel_backlight,
  output logic [2:0]       transcoder_clock_gate,
  output logic [2:0]       transcoder_pll_choice
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  power_ctrl_s  ctrl_r;
  logic [31:0]  routing_r;
  logic [1:0]   port_sel_r;
  power_state_s state_view;
  seq_state_e   seq_r;
  seq_state_e   seq_nxt;
  logic [15:0]  delay_r;
  logic [15:0]  delay_nxt;
  logic [15:0]  tick_cnt_r;
  logic         tick;
  logic         down_req_r;
  logic         bvalid_r;
  logic [1:0]   bresp_r;
  logic         rvalid_r;
  logic [31:0]  rdata_r;
  logic [1:0]   rresp_r;
  logic         wr_go;
  logic         unlocked;
  logic         protect_on;
  logic         assets_ready;
  logic         delay_done;
  logic [31:0]  strobe_mask;
  logic [31:0]  routing_keep;

  // ----------------------------------------------------------------
  // write and read handshake
  // ----------------------------------------------------------------
  // address and data are taken together; one write outstanding at most
  assign wr_go   = awvalid && wvalid && !bvalid_r;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = !rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strobe_mask[i*8 +: 8] = {8{wstrb[i]}};
    end
  end

  assign unlocked   = (ctrl_r.key == UNLOCK_KEY);
  assign protect_on = state_view.powered && !unlocked;

  // bits of the transcoder tied to the panel hold their value while protected
  always_comb begin
    routing_keep = 32'h00000000;
    for (int t = 0; t < 3; t++) begin
      if (protect_on && (panel_transcoder == t[1:0])) begin
        routing_keep[GATE_POS[t]]   = 1'b1;
        routing_keep[CHOICE_POS[t]] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      unique case (awaddr[19:2])
        OFS_POWER_CTRL[19:2], OFS_PLL_ROUTING[19:2],
        OFS_POWER_STATE[19:2], OFS_PORT_SETUP[19:2]: bresp_r <= RESP_OKAY;
        default: bresp_r <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= power_ctrl_s'(RST_POWER_CTRL);
    end else if (wr_go && awaddr[19:2] == OFS_POWER_CTRL[19:2]) begin
      ctrl_r <= power_ctrl_s'(((wdata & strobe_mask) | (ctrl_r & ~strobe_mask)) & 32'hFFFF000F);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routing_r <= RST_PLL_ROUTING;
    end else if (wr_go && awaddr[19:2] == OFS_PLL_ROUTING[19:2]) begin
      routing_r <= (((wdata & strobe_mask) | (routing_r & ~strobe_mask)) & ROUTING_MASK & ~routing_keep)
                   | (routing_r & routing_keep);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_sel_r <= PORT_LVDS;
    end else if (wr_go && awaddr[19:2] == OFS_PORT_SETUP[19:2] && wstrb[3] && !protect_on) begin
      port_sel_r <= wdata[31:30];
    end
  end

  // status address accepts writes but stores nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      unique case (araddr[19:2])
        OFS_POWER_CTRL[19:2]:  rdata_r <= ctrl_r;
        OFS_PLL_ROUTING[19:2]: rdata_r <= routing_r;
        OFS_POWER_STATE[19:2]: rdata_r <= state_view;
        OFS_PORT_SETUP[19:2]:  rdata_r <= {port_sel_r, 30'h00000000};
        default: begin
          rdata_r <= 32'h00000000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 16'h0000;
    end else if (tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick       = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  assign delay_done = (delay_r == 16'h0000);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign assets_ready = pll_locked && pipe_enabled && port_enabled[port_sel_r];

  // a reset warning arriving while powered with down_on_reset set is held until power-down begins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      down_req_r <= 1'b0;
    end else if (reset_warning && ctrl_r.down_on_reset && state_view.powered) begin
      down_req_r <= 1'b1;
    end else if (seq_r == SEQ_BL_OFF) begin
      down_req_r <= 1'b0;
    end
  end

  always_comb begin
    seq_nxt   = seq_r;
    delay_nxt = (tick && !delay_done) ? delay_r - 16'h0001 : delay_r;
    unique case (seq_r)
      SEQ_OFF: begin
        if (ctrl_r.power_target && assets_ready) begin
          seq_nxt   = SEQ_UP;
          delay_nxt = 16'(UP_DELAY_TICKS);
        end
      end
      SEQ_CYCLE: begin
        if (delay_done) begin
          seq_nxt = SEQ_OFF;
        end
      end
      SEQ_UP: begin
        if (delay_done) begin
          seq_nxt   = SEQ_BL_ON;
          delay_nxt = 16'(BL_ON_TICKS);
        end
      end
      SEQ_BL_ON: begin
        if (delay_done) begin
          seq_nxt = SEQ_ON;
        end
      end
      SEQ_ON: begin
        if (!ctrl_r.power_target || down_req_r) begin
          seq_nxt   = SEQ_BL_OFF;
          delay_nxt = 16'(BL_OFF_TICKS);
        end
      end
      SEQ_BL_OFF: begin
        if (delay_done) begin
          seq_nxt   = SEQ_DOWN;
          delay_nxt = 16'(DOWN_TICKS);
        end
      end
      SEQ_DOWN: begin
        if (delay_done) begin
          seq_nxt   = SEQ_CYCLE;
          delay_nxt = 16'(CYCLE_DELAY_T);
        end
      end
      default: seq_nxt = SEQ_OFF;
    endcase
  end

  // after reset the cycle delay runs with its default length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r   <= SEQ_CYCLE;
      delay_r <= 16'(CYCLE_DELAY_T);
    end else begin
      seq_r   <= seq_nxt;
      delay_r <= delay_nxt;
    end
  end

  // ----------------------------------------------------------------
  // live status and panel outputs
  // ----------------------------------------------------------------
  always_comb begin
    state_view              = power_state_s'(32'h00000000);
    state_view.powered      = (seq_r != SEQ_OFF) && (seq_r != SEQ_CYCLE);
    state_view.assets_ready = assets_ready;
    state_view.cycle_active = (seq_r == SEQ_CYCLE);
    unique case (seq_r)
      SEQ_UP, SEQ_BL_ON:    state_view.progress = PROG_UP;
      SEQ_BL_OFF, SEQ_DOWN: state_view.progress = PROG_DOWN;
      SEQ_CYCLE:            state_view.progress = ctrl_r.power_target ? PROG_UP : PROG_NONE;
      default:              state_view.progress = PROG_NONE;
    endcase
  end

  // outputs registered so the panel sees clean levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_vdd       <= 1'b0;
      panel_backlight <= 1'b0;
    end else begin
      panel_vdd       <= ctrl_r.supply_force_bit || state_view.powered;
      panel_backlight <= (seq_r == SEQ_ON) && ctrl_r.backlight_en
                         && (port_sel_r != PORT_LVDS);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transcoder_clock_gate <= 3'h0;
      transcoder_pll_choice <= 3'h0;
    end else begin
      for (int t = 0; t < 3; t++) begin
        transcoder_clock_gate[t] <= routing_r[GATE_POS[t]];
        transcoder_pll_choice[t] <= routing_r[CHOICE_POS[t]];
      end
    end
  end

endmodule : panel_power_sequencer

/* verilog/panel_seq_pkg.sv */
// shared constants and carriers for the panel power sequencer
package panel_seq_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [19:0] OFS_PLL_ROUTING = 20'hC7000;
  localparam logic [19:0] OFS_POWER_STATE = 20'hC7200;
  localparam logic [19:0] OFS_POWER_CTRL  = 20'hC7204;
  localparam logic [19:0] OFS_PORT_SETUP  = 20'hC7240;

  // ----------------------------------------------------------------
  // reset values and field constants
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_POWER_CTRL  = 32'h00000000;
  localparam logic [31:0] RST_PLL_ROUTING = 32'h00000000;
  localparam logic [31:0] RST_POWER_STATE = 32'h08000000;
  localparam logic [15:0] UNLOCK_KEY      = 16'hABCD;
  localparam logic [1:0]  PROG_NONE       = 2'h0;
  localparam logic [1:0]  PROG_UP         = 2'h1;
  localparam logic [1:0]  PROG_DOWN       = 2'h2;
  localparam logic [1:0]  PORT_DP_FIRST   = 2'h1;
  localparam logic [1:0]  PORT_LVDS       = 2'h0;
  // gate / choice bit positions, one pair per transcoder
  localparam int          GATE_POS [3]    = '{3, 7, 11};
  localparam int          CHOICE_POS [3]  = '{0, 4, 8};
  localparam logic [31:0] ROUTING_MASK    = 32'h00000999;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int TIME_BASE_NS    = 100000;
  localparam int TIME_BASE_CYC   = TIME_BASE_NS / CLK_PERIOD_NS;
  localparam int UP_DELAY_TICKS  = 500;
  localparam int BL_ON_TICKS     = 2000;
  localparam int BL_OFF_TICKS    = 2000;
  localparam int DOWN_TICKS      = 500;
  localparam int CYCLE_TICKS     = 5000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] key;
    logic [11:0] rsvd;
    logic        supply_force_bit;
    logic        backlight_en;
    logic        down_on_reset;
    logic        power_target;
  } power_ctrl_s;

  typedef struct packed {
    logic        powered;
    logic        assets_ready;
    logic [1:0]  progress;
    logic        cycle_active;
    logic [26:0] rsvd;
  } power_state_s;

  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_CYCLE, SEQ_UP, SEQ_BL_ON, SEQ_ON, SEQ_BL_OFF, SEQ_DOWN
  } seq_state_e;

endpackage : panel_seq_pkg

/* bench/panel_seq_monitor.sv */
// concurrent port checks for the panel power sequencer
`timescale 1ns/1ps
module panel_seq_monitor
  import panel_seq_pkg::*;
(
  // bus side
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [19:0] araddr,
  input wire logic        arvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // panel side
  input wire logic        panel_vdd,
  input wire logic        panel_backlight,
  input wire logic [2:0]  transcoder_clock_gate,
  input wire logic [2:0]  transcoder_pll_choice
);
  logic [17:0] ra;
  logic        rd_map;
  assign ra     = araddr[19:2];
  assign rd_map = ra inside {OFS_PLL_ROUTING[19:2], OFS_POWER_STATE[19:2],
                             OFS_POWER_CTRL[19:2], OFS_PORT_SETUP[19:2]};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    awvalid && wvalid && !bvalid;
  endsequence
  // two idle cycles cover the register and its output copy
  sequence wr_idle2;
    !(awvalid && wvalid && !bvalid) [*2];
  endsequence

  aw_ready_a: assert property (awready == (awvalid && wvalid && !bvalid)) else $error("awready mismatch");
  wr_ready_a: assert property (wready == awready) else $error("wready differs from awready");
  wr_answer_a: assert property (wr_take |=> bvalid) else $error("write not answered");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  rd_answer_a: assert property (arvalid && !rvalid |=> rvalid) else $error("read not answered");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");
  rd_unmapped_a: assert property (arvalid && !rvalid && !rd_map |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  backlight_vdd_a: assert property (panel_backlight |-> panel_vdd) else $error("backlight without vdd");
  routing_quiet_a: assert property (wr_idle2 |=> $stable(transcoder_clock_gate) && $stable(transcoder_pll_choice))
    else $error("routing moved without write");
endmodule : panel_seq_monitor

bind panel_power_sequencer panel_seq_monitor panel_seq_monitor_i (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .rdata, .rresp, .rvalid, .rready, .panel_vdd, .panel_backlight,
  .wready, .transcoder_clock_gate, .transcoder_pll_choice);

/* bench/panel_port_model.sv */
// far side model: pll, pipe and port readiness beside the panel
`timescale 1ns/1ps
module panel_port_model (
  // clock and bench control
  input  wire logic       aclk,
  input  wire logic       assets_on,
  // panel
  input  wire logic       panel_vdd,
  input  wire logic       panel_backlight,
  // asset status
  output logic            pll_locked,
  output logic            pipe_enabled,
  output logic [3:0]      port_enabled,
  output logic            bl_bad
);
  logic [3:0] lock_cnt_r;
  // lock takes a while, so readiness is not instant
  always_ff @(posedge aclk) begin
    if (!assets_on) lock_cnt_r <= 4'h0;
    else if (lock_cnt_r != 4'hF) lock_cnt_r <= lock_cnt_r + 4'h1;
  end
  assign pll_locked   = lock_cnt_r >= 4'h8;
  assign pipe_enabled = assets_on;
  assign port_enabled = {4{lock_cnt_r == 4'hF}};
  // plain always so the initial value and the sticky set share one process kind
  initial bl_bad = 1'b0;
  always @(posedge aclk) begin
    if (panel_backlight === 1'b1 && panel_vdd !== 1'b1) bl_bad <= 1'b1;
  end
endmodule : panel_port_model

/* bench/test_panel_power_sequencer.sv */
// self-checking bench for the panel power sequencer
`timescale 1ns/1ps
module test_panel_power_sequencer import panel_seq_pkg::*;;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic        awready, wready, arready, pll_locked, pipe_enabled, reset_warning, assets_on;
  logic        panel_vdd, panel_backlight, bl_bad;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, port_enabled;
  logic [2:0]  awprot, arprot, transcoder_clock_gate, transcoder_pll_choice;
  logic [1:0]  bresp, rresp, panel_transcoder;
  int          n_fail = 0;
  int          compares = 0;

  // short time base keeps a full power cycle near 20k clocks
  panel_power_sequencer #(.TICK_CYCLES(4), .CYCLE_DELAY_T(3)) panel_power_sequencer_i (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pll_locked,
    .pipe_enabled, .port_enabled, .panel_transcoder, .reset_warning, .panel_vdd, .panel_backlight,
    .transcoder_clock_gate, .transcoder_pll_choice);
  panel_port_model panel_port_model_i (.aclk, .assets_on, .panel_vdd, .panel_backlight, .pll_locked,
    .pipe_enabled, .port_enabled, .bl_bad);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, seen, exp);
    end
  endtask : chk

  // lag holds off the response ready so a standing answer is seen
  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                    input int lag = 0);
    logic       tk;
    logic [1:0] r;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(negedge aclk) tk = awready;
      @(posedge aclk);
    end while (!tk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    repeat (lag) @(posedge aclk);
    bready  <= 1'b1;
    do begin
      @(negedge aclk) tk = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!tk);
    bready <= 1'b0;
    chk(32'(r), 32'(er), "write response");
  endtask : wr

  task automatic rdr(input logic [19:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                     input int lag = 0);
    logic       tk;
    logic [1:0] r;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk) tk = arready;
      @(posedge aclk);
    end while (!tk);
    arvalid <= 1'b0;
    repeat (lag) @(posedge aclk);
    rready  <= 1'b1;
    do begin
      @(negedge aclk) tk = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!tk);
    rready <= 1'b0;
    chk(32'(r), 32'(er), "read response");
  endtask : rdr

  task automatic wait_st(input logic [31:0] m, input logic [31:0] v, input string s);
    int i;
    i = 0;
    do begin
      rdr(OFS_POWER_STATE, rd);
      i++;
    end while ((rd & m) !== v && i < 9000);
    chk(rd & m, v, s);
  endtask : wait_st

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rdr(OFS_POWER_STATE, rd);
    chk(rd, RST_POWER_STATE, "status reset");
    rdr(OFS_POWER_CTRL, rd);
    chk(rd, RST_POWER_CTRL, "control reset");
    rdr(OFS_PLL_ROUTING, rd);
    chk(rd, RST_PLL_ROUTING, "routing reset");
    rdr(20'hC7FF0, rd, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped read");
    wr(20'hC7FF0, 32'hFFFFFFFF, RESP_SLVERR);
    wait_st(32'hFFFFFFFF, 32'h0, "cycle delay ends");
  endtask : t_reset

  task automatic t_routing();
    wr(OFS_PLL_ROUTING, 32'hFFFFFFFF, RESP_OKAY, 1);
    rdr(OFS_PLL_ROUTING, rd, RESP_OKAY, 2);
    chk(rd, ROUTING_MASK, "routing readback");
    chk({26'h0, transcoder_clock_gate, transcoder_pll_choice}, 32'h3F, "all routed");
    wr(OFS_PLL_ROUTING, 32'h00000108);
    rdr(OFS_PLL_ROUTING, rd);
    chk({26'h0, transcoder_clock_gate, transcoder_pll_choice}, 32'h0C, "per transcoder");
    wr(OFS_POWER_STATE, 32'hFFFFFFFF);
    rdr(OFS_POWER_STATE, rd);
    chk(rd, 32'h0, "status write ignored");
    wr(OFS_PLL_ROUTING, 32'h0);
  endtask : t_routing

  task automatic t_refuse();
    wr(OFS_POWER_CTRL, 32'h1);
    repeat (40) @(posedge aclk);
    rdr(OFS_POWER_STATE, rd);
    chk(rd, 32'h0, "no power-up unready");
    chk(32'(panel_vdd), 32'h0, "vdd stays off");
    wr(OFS_POWER_CTRL, 32'h8);
    repeat (2) @(posedge aclk);
    chk(32'(panel_vdd), 32'h1, "vdd forced");
    wr(OFS_POWER_CTRL, 32'h0);
    repeat (2) @(posedge aclk);
    chk(32'(panel_vdd), 32'h0, "vdd released");
  endtask : t_refuse

  task automatic t_power();
    wr(OFS_PORT_SETUP, 32'h40000000);
    assets_on <= 1'b1;
    wait_st(32'h40000000, 32'h40000000, "assets ready");
    wr(OFS_POWER_CTRL, 32'h1);
    wait_st(32'hB0000000, 32'h90000000, "powering up");
    chk(32'(panel_vdd), 32'h1, "vdd up");
    wr(OFS_PLL_ROUTING, 32'h00000099);
    rdr(OFS_PLL_ROUTING, rd);
    chk(rd, 32'h00000090, "panel bits kept");
    panel_transcoder <= 2'h2;
    wr(OFS_PLL_ROUTING, 32'h00000999);
    rdr(OFS_PLL_ROUTING, rd);
    chk(rd, 32'h00000099, "third transcoder kept");
    panel_transcoder <= 2'h0;
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0001});
    wr(OFS_PLL_ROUTING, 32'h00000999);
    rdr(OFS_PLL_ROUTING, rd);
    chk(rd, 32'h00000999, "key unlocks");
    wait_st(32'hB0000000, 32'h80000000, "panel on");
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0005});
    repeat (3) @(posedge aclk);
    chk(32'(panel_backlight), 32'h1, "backlight on");
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0000});
    wait_st(32'hB0000000, 32'hA0000000, "powering down");
    chk(32'(panel_backlight), 32'h0, "backlight off");
    wait_st(32'h88000000, 32'h08000000, "down done");
    wait_st(32'h08000000, 32'h0, "cycle delay over");
    wr(OFS_PLL_ROUTING, 32'h0);
  endtask : t_power

  task automatic t_warn();
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0002});
    reset_warning <= 1'b1;
    @(posedge aclk);
    reset_warning <= 1'b0;
    repeat (4) @(posedge aclk);
    rdr(OFS_POWER_STATE, rd);
    chk(rd, 32'h40000000, "warning ignored off");
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0001});
    wait_st(32'hB0000000, 32'h80000000, "on for warning");
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0003});
    reset_warning <= 1'b1;
    @(posedge aclk);
    reset_warning <= 1'b0;
    wait_st(32'hB0000000, 32'hA0000000, "warning powers down");
    wr(OFS_POWER_CTRL, {UNLOCK_KEY, 16'h0000});
    wait_st(32'h88000000, 32'h0, "warning down done");
  endtask : t_warn

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (80000) @(posedge aclk);
    n_fail++;
    complete_run();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, reset_warning, assets_on} = 8'h00;
    {awaddr, araddr, wdata} = '0;
    {awprot, arprot, panel_transcoder} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_routing();
    t_refuse();
    t_power();
    t_warn();
    chk(32'(bl_bad), 32'h0, "backlight seen unpowered");
    complete_run();
  end
endmodule : test_panel_power_sequencer
